// file: rtl/rcsa_defs.svh
// Constants for the run-command source arbiter
`ifndef RCSA_DEFS_SVH
`define RCSA_DEFS_SVH
// Register byte offsets
`define RCSA_CFG_SRC_OFF    12'h000
`define RCSA_CFG_SER_OFF    12'h004
`define RCSA_CFG_MISC_OFF   12'h008
`define RCSA_STATUS_OFF     12'h00c
`define RCSA_KEY_OFF        12'h010
// Command source codes
`define RCSA_SRC_KEYPAD     3'h0
`define RCSA_SRC_TWO_TERM   3'h1
`define RCSA_SRC_RUN_DIR    3'h2
`define RCSA_SRC_SERIAL     3'h3
`define RCSA_SRC_FIELD_BUS  3'h4
`define RCSA_SRC_USER_SEQ   3'h5
`define RCSA_SRC_MAX        3'h5
// Serial settings
`define RCSA_STATION_MIN    8'h01
`define RCSA_STATION_MAX    8'hfa
`define RCSA_STATION_RST    8'h01
`define RCSA_PROTO_RST      2'h0
`define RCSA_PROTO_MAX      2'h2
`define RCSA_SPEED_RST      3'h3
`define RCSA_FRAME_RST      2'h0
// Mode key and direction block
`define RCSA_MODEKEY_LOCREM 2'h2
`define RCSA_MODEKEY_MAX    2'h2
`define RCSA_DIR_NONE       2'h0
`define RCSA_DIR_NO_FWD     2'h1
`define RCSA_DIR_NO_REV     2'h2
`define RCSA_TERM_PERMIT    6'h0d
// Set lamp flash counter width and the smallest width that still flashes
`define RCSA_FLASH_BITS     24
`define RCSA_FLASH_MIN_BITS 2
`endif

// file: rtl/rcsa_pkg.sv
// Types for the run-command source arbiter
package rcsa_pkg;
  typedef logic [2:0] rcsa_src_t;
  typedef logic [1:0] rcsa_dir_t;
endpackage

// file: rtl/rcsa_rearm.sv
// Rearm gate: run terminals honoured only after all went inactive
`include "rcsa_defs.svh"
module rcsa_rearm (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic block_req,
  input  wire logic any_active,
  output logic      armed
);
  typedef struct packed {
    logic armed;
  } rcsa_rearm_st_t;
  rcsa_rearm_st_t st_reg;
  rcsa_rearm_st_t st_next;

  // Block on request; rearm once every terminal is seen inactive
  always_comb begin
    st_next = st_reg;
    if (block_req) begin
      st_next.armed = 1'b0;
    end else if (!any_active) begin
      st_next.armed = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign armed = st_reg.armed;
endmodule

// file: rtl/rcsa_top.sv
// Run-command source arbiter with APB register access
// Behaviour
// - Source 3 takes run commands only from the serial port.
// - Station identifier accepted 1 to 250, default 1.
// - Protocol default 0, speed 0-7 default 3, frame 0-3 default 0.
// - Mode key function 2 toggles local/remote; setting it forces remote.
// - Key in remote: go local, flash set lamp, keypad run key rules.
// - Key in local: go remote, lamp off, follow configured source.
// - Local to remote leaves all configuration untouched.
// - Local jog acts only with a permit terminal assigned and active.
// - Power-on run off: terminals rearm only after all went inactive.
// - Fault reset during run: power up local; remote stops, rearm.
// - Remote to local while running stops the drive.
// - Local to remote on terminals keeps running; reverse input wins.
// - Local to remote on digital source stops until next command.
// - Remote runs from the selected input device commands.
// - Direction block 0 none, 1 forward, 2 reverse; refuse that way.
// - Reverse key with prevention set decelerates to stop, stays on.
// - Source codes 0 keypad,1 two-term,2 run-dir,3 serial,4 bus,5 user.
// - Two-terminal mode: both or neither active means stop.
// - Run-dir mode: forward input runs, reverse input picks direction.
//
// The register addresses and register access over APB were left to the implementer.
`include "rcsa_defs.svh"
module rcsa_top
  import rcsa_pkg::*;
#(
  parameter int unsigned FlashBits = `RCSA_FLASH_BITS
)
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mode_toggle_key,
  input  wire logic        key_run,
  input  wire logic        key_stop,
  input  wire logic        key_rev,
  input  wire logic        key_jog,
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  input  wire logic        jog_input,
  input  wire logic        preexcite_input,
  input  wire logic        permit_input,
  input  wire logic        fault_reset_boot,
  input  wire logic        serial_run,
  input  wire logic        serial_rev,
  input  wire logic        serial_stop,
  input  wire logic        bus_run,
  input  wire logic        bus_rev,
  input  wire logic        user_run,
  input  wire logic        user_rev,
  output logic             run_cmd,
  output logic             rev_cmd,
  output logic             jog_cmd,
  output logic             decel_stop,
  output logic             set_lamp_flash,
  output logic             local_mode
);
  // A one-bit counter would toggle the lamp every clock instead of visibly flashing it
  if (FlashBits < `RCSA_FLASH_MIN_BITS) begin : g_flash_check
    $error("FlashBits too small for a flashing lamp");
  end

  typedef struct packed {
    rcsa_src_t  src;
    logic [5:0] permit_func;
    logic [7:0] station;
    logic [1:0] proto;
    logic [2:0] speed;
    logic [1:0] frame;
    logic [1:0] mode_key_fn;
    rcsa_dir_t  dir_block;
    logic       pwr_on_run;
    logic       local_flag;
    logic       key_q;
    logic       dig_run;
    logic       dig_rev;
    logic       running;
    logic       boot_done;
    logic [FlashBits-1:0] flash_cnt;
    logic [31:0] prdata;
    logic       pready;
    logic       pslverr;
    logic       run_o;
    logic       rev_o;
    logic       jog_o;
    logic       decel_o;
    logic       lamp_o;
  } rcsa_st_t;

  rcsa_st_t st_reg;
  rcsa_st_t st_next;
  logic     term_armed;
  logic     rearm_req;
  logic     any_term;

  // Terminals that must all drop before terminal commands rearm
  assign any_term = forward_run_input | reverse_run_input | jog_input | preexcite_input;

  rcsa_rearm u_rearm (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .block_req  (rearm_req),
    .any_active (any_term),
    .armed      (term_armed)
  );

  // Main next-state logic
  always_comb begin
    logic      acc;
    logic      wr;
    logic      key_edge;
    logic      to_local;
    logic      to_remote;
    logic      term_src;
    logic      want_run;
    logic      want_rev;
    logic      want_jog;
    logic [31:0] rd;
    st_next   = st_reg;
    acc       = psel & penable & ~st_reg.pready;
    wr        = acc & pwrite;
    rd        = 32'h0;
    rearm_req = 1'b0;
    key_edge  = mode_toggle_key & ~st_reg.key_q;
    to_local  = 1'b0;
    to_remote = 1'b0;
    term_src  = (st_reg.src == `RCSA_SRC_TWO_TERM) || (st_reg.src == `RCSA_SRC_RUN_DIR);
    want_run  = 1'b0;
    want_rev  = 1'b0;
    want_jog  = 1'b0;
    st_next.key_q = mode_toggle_key;

    // Boot: fault reset during run forces local; power-on run gate
    if (!st_reg.boot_done) begin
      st_next.boot_done = 1'b1;
      st_next.local_flag = fault_reset_boot;
      rearm_req = !st_reg.pwr_on_run | fault_reset_boot;
    end

    // Mode key toggles only when configured for local/remote
    if (key_edge && st_reg.mode_key_fn == `RCSA_MODEKEY_LOCREM) begin
      to_local  = !st_reg.local_flag;
      to_remote = st_reg.local_flag;
    end

    // APB access, one wait state; bad offset, bad value or status write sets pslverr
    st_next.pready  = acc;
    st_next.pslverr = 1'b0;
    if (acc) begin
      case (paddr)
        `RCSA_CFG_SRC_OFF: begin
          rd = {23'h0, st_reg.permit_func, st_reg.src};
          if (wr) begin
            if (pwdata[2:0] > `RCSA_SRC_MAX) begin
              st_next.pslverr = 1'b1;
            end else begin
              st_next.src = pwdata[2:0];
              st_next.permit_func = pwdata[8:3];
            end
          end
        end
        `RCSA_CFG_SER_OFF: begin
          rd = {17'h0, st_reg.frame, st_reg.speed, st_reg.proto, st_reg.station};
          if (wr) begin
            if (pwdata[7:0] < `RCSA_STATION_MIN || pwdata[7:0] > `RCSA_STATION_MAX ||
                pwdata[9:8] > `RCSA_PROTO_MAX) begin
              st_next.pslverr = 1'b1;
            end else begin
              st_next.station = pwdata[7:0];
              st_next.proto   = pwdata[9:8];
              st_next.speed   = pwdata[12:10];
              st_next.frame   = pwdata[14:13];
            end
          end
        end
        `RCSA_CFG_MISC_OFF: begin
          rd = {27'h0, st_reg.pwr_on_run, st_reg.dir_block, st_reg.mode_key_fn};
          if (wr) begin
            if (pwdata[1:0] > `RCSA_MODEKEY_MAX || pwdata[3:2] == 2'h3) begin
              st_next.pslverr = 1'b1;
            end else begin
              st_next.mode_key_fn = pwdata[1:0];
              st_next.dir_block   = pwdata[3:2];
              st_next.pwr_on_run  = pwdata[4];
              // Selecting local/remote forces remote at once
              if (pwdata[1:0] == `RCSA_MODEKEY_LOCREM && st_reg.local_flag) begin
                to_remote = 1'b1;
                to_local  = 1'b0;
              end
            end
          end
        end
        `RCSA_STATUS_OFF: begin
          rd = {26'h0, term_armed, st_reg.decel_o, st_reg.jog_o, st_reg.rev_o, st_reg.run_o,
                st_reg.local_flag};
          if (wr) begin
            st_next.pslverr = 1'b1;
          end
        end
        `RCSA_KEY_OFF: begin
          rd = 32'h0;
        end
        default: begin
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    st_next.prdata = (acc && !pwrite) ? rd : 32'h0;

    // Mode change: to local or to a digital source stops, configuration never touched
    if (to_local) begin
      st_next.local_flag = 1'b1;
      st_next.dig_run = 1'b0;
    end
    if (to_remote) begin
      st_next.local_flag = 1'b0;
      if (!term_src || fault_reset_boot) begin
        st_next.dig_run = 1'b0;
      end
      if (fault_reset_boot) begin
        rearm_req = 1'b1;
      end
    end

    // Keypad latches a digital run request
    if ((st_next.local_flag || st_reg.src == `RCSA_SRC_KEYPAD) && !to_local && !to_remote) begin
      if (key_stop) begin
        st_next.dig_run = 1'b0;
      end else if (key_run) begin
        st_next.dig_run = 1'b1;
      end
      if (key_rev) begin
        st_next.dig_rev = ~st_reg.dig_rev;
      end
    end

    // Command selection by the single local flag
    if (st_reg.local_flag) begin
      want_run = st_reg.dig_run;
      want_rev = st_reg.dig_rev;
      want_jog = (key_jog || jog_input) && permit_input &&
                 st_reg.permit_func == `RCSA_TERM_PERMIT;
    end else begin
      case (st_reg.src)
        `RCSA_SRC_KEYPAD: begin
          want_run = st_reg.dig_run;
          want_rev = st_reg.dig_rev;
        end
        `RCSA_SRC_TWO_TERM: begin
          want_run = term_armed & (forward_run_input ^ reverse_run_input);
          want_rev = reverse_run_input;
          want_jog = term_armed & jog_input;
        end
        `RCSA_SRC_RUN_DIR: begin
          want_run = term_armed & forward_run_input;
          want_rev = reverse_run_input;
          want_jog = term_armed & jog_input;
        end
        `RCSA_SRC_SERIAL: begin
          want_run = serial_run & ~serial_stop;
          want_rev = serial_rev;
        end
        `RCSA_SRC_FIELD_BUS: begin
          want_run = bus_run;
          want_rev = bus_rev;
        end
        `RCSA_SRC_USER_SEQ: begin
          want_run = user_run;
          want_rev = user_rev;
        end
        default: begin
          want_run = 1'b0;
        end
      endcase
    end

    // Direction prevention: refused direction decelerates to stop
    st_next.decel_o = 1'b0;
    if ((want_run || want_jog) &&
        ((st_reg.dir_block == `RCSA_DIR_NO_FWD && !want_rev) ||
         (st_reg.dir_block == `RCSA_DIR_NO_REV && want_rev))) begin
      want_run = 1'b0;
      want_jog = 1'b0;
      st_next.decel_o = 1'b1;
    end
    if (key_rev && st_reg.dir_block != `RCSA_DIR_NONE && st_reg.local_flag) begin
      st_next.dig_run = 1'b0;
      st_next.decel_o = 1'b1;
    end
    if (to_local || to_remote) begin
      want_run = want_run & term_src & ~to_local;
    end

    st_next.run_o   = want_run;
    st_next.rev_o   = want_rev;
    st_next.jog_o   = want_jog;
    st_next.running = want_run | want_jog;

    // Set lamp flashes in local mode, dark in remote
    st_next.flash_cnt = st_next.local_flag ? st_reg.flash_cnt + 1'b1 : '0;
    st_next.lamp_o    = st_next.local_flag & st_reg.flash_cnt[FlashBits-1];
  end

  // Single state register; reset loads the documented defaults
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg         <= '0;
      st_reg.src     <= `RCSA_SRC_KEYPAD;
      st_reg.station <= `RCSA_STATION_RST;
      st_reg.proto   <= `RCSA_PROTO_RST;
      st_reg.speed   <= `RCSA_SPEED_RST;
      st_reg.frame   <= `RCSA_FRAME_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata         = st_reg.prdata;
  assign pready         = st_reg.pready;
  assign pslverr        = st_reg.pslverr;
  assign run_cmd        = st_reg.run_o;
  assign rev_cmd        = st_reg.rev_o;
  assign jog_cmd        = st_reg.jog_o;
  assign decel_stop     = st_reg.decel_o;
  assign set_lamp_flash = st_reg.lamp_o;
  assign local_mode     = st_reg.local_flag;
endmodule

// file: sim/rcsa_ctrl_model.sv
// Upper-level controller model driving the serial command lines
module rcsa_ctrl_model #(
  parameter logic [7:0] STATION = 8'h05
) (
  input  wire logic       mclk,
  input  wire logic [7:0] dest_id,
  input  wire logic       req_run,
  input  wire logic       req_rev,
  output logic            serial_run,
  output logic            serial_rev,
  output logic            serial_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines until the first frame for this station
  initial {serial_run, serial_rev, serial_stop} = 3'b001;
  // Frames for another station leave the lines as they were
  always @(posedge mclk) begin
    if (dest_id == STATION) begin
      serial_run  <= req_run;
      serial_rev  <= req_rev;
      serial_stop <= !req_run;
    end
  end
endmodule

// file: sim/rcsa_monitor.sv
// Port assertions for the run-command source arbiter
`include "rcsa_defs.svh"
module rcsa_monitor (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        reverse_run_input,
  input wire logic        forward_run_input,
  input wire logic        serial_run,
  input wire logic        run_cmd,
  input wire logic        rev_cmd,
  input wire logic        decel_stop,
  input wire logic        set_lamp_flash,
  input wire logic        local_mode
);
  logic [2:0] src_reg;
  logic [1:0] dirb_reg;
  // Shadow config, one cycle behind the device, so checks wait for it to settle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      src_reg  <= 3'h0;
      dirb_reg <= 2'h0;
    end else if (psel && penable && pwrite && pready && !pslverr) begin
      if (paddr == `RCSA_CFG_SRC_OFF) src_reg <= pwdata[2:0];
      if (paddr == `RCSA_CFG_MISC_OFF) dirb_reg <= pwdata[3:2];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_rem;
    !local_mode && $past(!local_mode);
  endsequence
  take_answer_a: assert property (s_take |=> pready)
    else $error("access not answered");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  station_range_a: assert property (s_take ##0 (pwrite && paddr == `RCSA_CFG_SER_OFF &&
    (pwdata[7:0] == 8'h00 || pwdata[7:0] > 8'hfa)) |=> pslverr) else $error("bad station accepted");
  remote_lamp_a: assert property (s_rem |-> !set_lamp_flash)
    else $error("lamp lit in remote");
  local_stop_a: assert property ($rose(local_mode) |-> !run_cmd)
    else $error("run kept on local switch");
  fwd_block_a: assert property (dirb_reg == 2'h1 && $past(dirb_reg) == 2'h1 |->
    !(run_cmd && !rev_cmd && !decel_stop)) else $error("forward run not refused");
  two_term_a: assert property (s_rem ##0 (src_reg == 3'h1 && $stable(src_reg) &&
    $past(forward_run_input) == $past(reverse_run_input)) |-> !run_cmd) else $error("two-terminal stop missed");
  run_dir_a: assert property (s_rem ##0 (src_reg == 3'h2 && $stable(src_reg) && dirb_reg == 2'h0 &&
    run_cmd) |-> rev_cmd == $past(reverse_run_input)) else $error("direction input ignored");
  serial_only_a: assert property (s_rem ##0 (src_reg == 3'h3 && $stable(src_reg) && $rose(run_cmd))
    |-> $past(serial_run)) else $error("serial source bypassed");
endmodule
bind rcsa_top rcsa_monitor u_mon (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reverse_run_input(reverse_run_input), .forward_run_input(forward_run_input), .serial_run(serial_run),
  .run_cmd(run_cmd), .rev_cmd(rev_cmd), .decel_stop(decel_stop), .set_lamp_flash(set_lamp_flash),
  .local_mode(local_mode));

// file: sim/tb.sv
// Self-checking bench for the run-command source arbiter
`include "rcsa_defs.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        mkey, k_run, k_stop, k_rev, fwd, rev, frb, s_run, s_rev, s_stop;
  logic        b_run, b_rev, u_run, u_rev, run_cmd, rev_cmd, decel_stop, lamp, local_mode, q_run;
  logic        k_jog, perm, jog;
  logic [7:0]  dest;
  int          errors, checks_done, f, r;
  int          st_q[$];
  // Short flash counter so the lamp visibly flashes within the run
  rcsa_top #(.FlashBits(4)) uut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_toggle_key(mkey), .key_run(k_run), .key_stop(k_stop), .key_rev(k_rev), .key_jog(k_jog),
    .forward_run_input(fwd), .reverse_run_input(rev), .jog_input(1'b0), .preexcite_input(1'b0),
    .permit_input(perm), .fault_reset_boot(frb), .serial_run(s_run), .serial_rev(s_rev),
    .serial_stop(s_stop), .bus_run(b_run), .bus_rev(b_rev), .user_run(u_run), .user_rev(u_rev),
    .run_cmd(run_cmd), .rev_cmd(rev_cmd), .jog_cmd(jog), .decel_stop(decel_stop),
    .set_lamp_flash(lamp), .local_mode(local_mode));
  rcsa_ctrl_model #(.STATION(8'h05)) u_ctrl (.mclk(mclk), .dest_id(dest), .req_run(q_run),
    .req_rev(1'b0), .serial_run(s_run), .serial_rev(s_rev), .serial_stop(s_stop));
  initial mclk = 1'b0;
  // Free-running 250 MHz clock
  always #2 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer; waits on pready, bounded so a hang shows as a mismatch
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1, pready)
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic rc(input logic [11:0] a, input int d, input int e);
    apb(1'b0, a, 32'h0);
    `CHK("rdata", d, rdv)
    `CHK("rerr", e, erv)
  endtask
  task automatic wc(input logic [11:0] a, input int d, input int e);
    apb(1'b1, a, d);
    `CHK("werr", e, erv)
  endtask
  // Keys: 0 run, 1 stop, 2 reverse, 3 mode; one-cycle press
  task automatic keyp(input int k);
    {k_run, k_stop, k_rev, mkey} <= {k == 0, k == 1, k == 2, k == 3};
    tick(1);
    {k_run, k_stop, k_rev, mkey} <= 4'h0;
    tick(2);
  endtask
  // Terminal model: two-terminal runs on exactly one input, run-dir on forward
  function automatic int t_run(int s, int a, int b);
    return (s == 1) ? (a ^ b) : a;
  endfunction
  task automatic term(input int s, input int a, input int b);
    fwd <= a[0];
    rev <= b[0];
    tick(2);
    `CHK("run", t_run(s, a, b), run_cmd)
    `CHK("rev", t_run(s, a, b) & b, run_cmd & rev_cmd)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the expected run
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {psel, penable, pwrite, mkey, k_run, k_stop, k_rev, rev, b_run, b_rev, u_run, u_rev, q_run, k_jog, perm} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dest = 8'h00;
    fwd = 1'b1;
    frb = 1'b1;
    errors = 0;
    checks_done = 0;
    rst_b = 1'b0;
    tick(12);
    rst_b <= 1'b1;
    void'($urandom(40527));
    tick(2);
    frb <= 1'b0;
    `CHK("boot local", 1, local_mode)
    rc(`RCSA_CFG_SRC_OFF, 0, 0);
    rc(`RCSA_CFG_SER_OFF, 32'h0c01, 0);
    rc(`RCSA_CFG_MISC_OFF, 0, 0);
    rc(`RCSA_KEY_OFF, 0, 0);
    rc(12'h020, 0, 1);
    wc(`RCSA_STATUS_OFF, 1, 1);
    st_q = '{250, 251, 0, 1 + $urandom % 250};
    foreach (st_q[i]) wc(`RCSA_CFG_SER_OFF, 32'h0c00 | st_q[i], st_q[i] < 1 || st_q[i] > 250);
    wc(`RCSA_CFG_SER_OFF, 32'h0c05, 0);
    rc(`RCSA_CFG_SER_OFF, 32'h0c05, 0);
    $display("test registers done");
    wc(`RCSA_CFG_SRC_OFF, 1, 0);
    wc(`RCSA_CFG_MISC_OFF, 2, 0);
    tick(2);
    `CHK("remote", 0, local_mode)
    `CHK("gated", 0, run_cmd)
    term(1, 0, 0);
    term(1, 1, 0);
    term(1, 1, 1);
    term(1, 0, 1);
    term(1, 0, 0);
    $display("test terminals done");
    wc(`RCSA_CFG_SRC_OFF, 2, 0);
    term(2, 1, 0);
    keyp(3);
    `CHK("local", 1, local_mode)
    `CHK("stop local", 0, run_cmd)
    rev <= 1'b1;
    keyp(3);
    `CHK("remote rev", 3, {run_cmd, rev_cmd})
    rc(`RCSA_CFG_SRC_OFF, 2, 0);
    repeat (8) begin
      f = $urandom % 2;
      r = $urandom % 2;
      term(2, f, r);
    end
    $display("test mode key done");
    wc(`RCSA_CFG_MISC_OFF, 6, 0);
    term(2, 1, 1);
    fwd <= 1'b1;
    rev <= 1'b0;
    tick(3);
    `CHK("fwd refused", 0, run_cmd & ~rev_cmd & ~decel_stop)
    {fwd, rev} <= 2'b00;
    wc(`RCSA_CFG_MISC_OFF, 10, 0);
    wc(`RCSA_CFG_SRC_OFF, 0, 0);
    keyp(0);
    `CHK("key run", 1, run_cmd)
    keyp(2);
    `CHK("rev refused", 1, decel_stop)
    keyp(1);
    `CHK("key stop", 0, run_cmd)
    // Local mode: lamp flashes, jog needs the permit terminal, reverse key stops
    wc(`RCSA_CFG_MISC_OFF, 2, 0);
    wc(`RCSA_CFG_SRC_OFF, 32'h68, 0);
    keyp(3);
    `CHK("local again", 1, local_mode)
    f = 0;
    repeat (16) begin
      tick(1);
      f += lamp;
    end
    `CHK("lamp flash", 8, f)
    k_jog <= 1'b1;
    perm <= 1'b0;
    tick(2);
    `CHK("jog no permit", 0, jog)
    perm <= 1'b1;
    tick(2);
    `CHK("jog permit", 1, jog)
    {k_jog, perm} <= 2'b00;
    wc(`RCSA_CFG_MISC_OFF, 4, 0);
    keyp(0);
    `CHK("local key run", 1, run_cmd)
    k_rev <= 1'b1;
    tick(1);
    k_rev <= 1'b0;
    tick(1);
    `CHK("rev key decel", 1, decel_stop)
    tick(2);
    `CHK("rev key stop", 0, run_cmd)
    wc(`RCSA_CFG_MISC_OFF, 2, 0);
    tick(2);
    `CHK("forced remote", 0, local_mode)
    `CHK("lamp off", 0, lamp)
    $display("test keypad done");
    wc(`RCSA_CFG_MISC_OFF, 2, 0);
    wc(`RCSA_CFG_SRC_OFF, 3, 0);
    fwd <= 1'b1;
    dest <= 8'h05;
    q_run <= 1'b1;
    tick(4);
    `CHK("serial run", 1, run_cmd)
    dest <= 8'h06;
    q_run <= 1'b0;
    tick(4);
    `CHK("other station", 1, run_cmd)
    dest <= 8'h05;
    tick(4);
    `CHK("serial stop", 0, run_cmd)
    fwd <= 1'b0;
    for (int s = 4; s < 6; s++) begin
      r = $urandom % 2;
      wc(`RCSA_CFG_SRC_OFF, s, 0);
      {b_run, b_rev, u_run, u_rev} <= {s == 4, r[0] && s == 4, s == 5, r[0] && s == 5};
      tick(3);
      `CHK("digital run", 1 + 2 * r, {rev_cmd, run_cmd})
      {b_run, u_run} <= 2'b00;
      tick(3);
    end
    $display("test remote sources done");
    // Second reset after a fault: boot local, remote switch must block terminals
    rst_b <= 1'b0;
    frb <= 1'b1;
    tick(4);
    rst_b <= 1'b1;
    tick(2);
    `CHK("fault boot local", 1, local_mode)
    tick(2);
    fwd <= 1'b1;
    wc(`RCSA_CFG_SRC_OFF, 1, 0);
    wc(`RCSA_CFG_MISC_OFF, 2, 0);
    tick(2);
    `CHK("fault remote", 0, local_mode)
    `CHK("fault blocked", 0, run_cmd)
    frb <= 1'b0;
    term(1, 0, 0);
    term(1, 1, 0);
    $display("test fault reset done");
    tally_and_finish();
  end
endmodule
